// ### logic/fli_interlock.sv
// Result-latency scoreboard, adjacency adjustments, stage locks and branch fetch timing.
// Assumes the decoder holds an instruction until issue_go and then presents the next.
//
// What this block does
// RULE_01 - Track a latency per written register, including accumulators and fp status.
// RULE_02 - Branch latency counts cycles until the target instruction is fetched.
// RULE_03 - Conditional branch: 2 cycles with nonzero displacement, 1 with zero.
// RULE_04 - Double precision gives odd half, even half and fp status latencies.
// RULE_05 - Matrix transform gives four element latencies plus fp status latency.
// RULE_06 - Multiply-accumulate tracks both address registers, then high, then low.
// RULE_07 - Plain multiplies track accumulator high then accumulator low latency.
// RULE_08 - A stage lock is stage, start cycle and count; start 1 is decode.
// RULE_09 - Fp computation before fp store or communication move shrinks by one.
// RULE_10 - Load of shift amount before dynamic shift grows by one.
// RULE_11 - Load/store group under 3 before double, inner product, matrix becomes 3.
// RULE_12 - Multiply before accumulator push has latency 5.
// RULE_13 - Back to back multiplies have latency 2.
// RULE_14 - Accumulator load: 4 before accumulator push, 1 before multiply.
// RULE_15 - After bank swap or size toggle, fp load/store must not pair.
// RULE_16 - Single truncate before communication move has latency 1.
// RULE_17 - Stall any instruction touching a register whose latency is pending.
// RULE_18 - Hold decode while a needed stage is locked by an earlier instruction.
`timescale 1ns/1ps
module fli_interlock (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Decode slot
    input wire logic dec_valid,
    input wire fli_pkg::fli_op_t dec_op,
    input wire logic dec_is_load,
    input wire logic dec_pair_ls_fp,
    // Sources; slot 0 holds the shift amount of a dynamic shift
    input wire logic [fli_pkg::NSRC-1:0] dec_src_en,
    input wire logic [fli_pkg::REG_W-1:0] dec_src_id [fli_pkg::NSRC],
    // Destinations in documented order, each with its base latency
    input wire logic [fli_pkg::NDST-1:0] dec_dst_en,
    input wire logic [fli_pkg::REG_W-1:0] dec_dst_id [fli_pkg::NDST],
    input wire logic [fli_pkg::LAT_W-1:0] dec_dst_lat [fli_pkg::NDST],
    // Stage locks
    input wire fli_pkg::fli_stage_t dec_lock_stage [fli_pkg::NLOCK],
    input wire logic [fli_pkg::LAT_W-1:0] dec_lock_start [fli_pkg::NLOCK],
    input wire logic [fli_pkg::LAT_W-1:0] dec_lock_cycles [fli_pkg::NLOCK],
    // Branch
    input wire logic [fli_pkg::LAT_W-1:0] dec_br_lat,
    input wire logic dec_br_disp_zero,
    // Issue results
    output logic issue_go,
    output logic issue_pair_ok,
    output logic fetch_target,
    output logic stall_dep,
    output logic stall_lock
);
    import fli_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic logic is_mul(input fli_op_t op);
        return (op == OP_MUL) || (op == OP_MAC);
    endfunction

    function automatic logic is_fp_calc(input fli_op_t op);
        return (op == OP_FP_CALC) || (op == OP_DBL) || (op == OP_INNER) || (op == OP_MTX) || (op == OP_TRUNC_SGL);
    endfunction

    // Cycles still to wait, with the adjacency adjustment against the previous instruction
    function automatic logic [LAT_W:0] eff_wait(input logic [LAT_W-1:0] left, input logic [LAT_W-1:0] orig,
                                                input logic hit, input fli_op_t prv, input logic prv_load,
                                                input fli_op_t cur, input logic shift_src, input logic [LAT_W:0] age);
        logic [LAT_W:0] tgt;
        logic [LAT_W:0] l6;
        logic [LAT_W:0] o6;
        tgt = {1'b0, orig};
        l6 = {1'b0, left};
        o6 = {1'b0, orig};
        if (prv == OP_TRUNC_SGL && cur == OP_FP_COMMUNICATION_REG_MOVE) begin
            tgt = {1'b0, LAT_TRUNC_MOVE}; // RULE_16
        end else if (is_fp_calc(prv) && (cur == OP_FP_STORE || cur == OP_FP_COMMUNICATION_REG_MOVE || cur == OP_FP_COMMUNICATION_REG_PUSH)) begin
            tgt = (orig >= LAT_FP_SHRINK) ? o6 - {1'b0, LAT_FP_SHRINK} : '0; // RULE_09
        end else if (prv_load && cur == OP_SHIFT_DYN && shift_src) begin
            tgt = o6 + {1'b0, LAT_SHIFT_GROW}; // RULE_10
        end else if (prv == OP_LS && orig < LAT_LS_MIN && (cur == OP_DBL || cur == OP_INNER || cur == OP_MTX)) begin
            tgt = {1'b0, LAT_LS_MIN}; // RULE_11
        end else if (is_mul(prv) && cur == OP_PUSH_ACC) begin
            tgt = {1'b0, LAT_ACC_PUSH}; // RULE_12
        end else if (is_mul(prv) && is_mul(cur)) begin
            tgt = {1'b0, LAT_MUL_CHAIN}; // RULE_13
        end else if (prv == OP_LOAD_ACC && cur == OP_PUSH_ACC) begin
            tgt = {1'b0, LAT_LDACC_PUSH}; // RULE_14
        end else if (prv == OP_LOAD_ACC && is_mul(cur)) begin
            tgt = {1'b0, LAT_LDACC_MUL}; // RULE_14
        end
        if (!hit) begin
            return l6;
        end
        // Counted from the writer's take, so a raised latency outlives the base count
        return (tgt > age) ? tgt - age : '0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Scoreboard state
    logic [LAT_W-1:0] lat_left [NREG];
    logic [LAT_W-1:0] lat_orig [NREG];
    logic [NREG-1:0] prev_wr;
    fli_op_t prev_op;
    logic prev_load;
    logic [LAT_W-1:0] next_lat_left [NREG];
    logic [LAT_W-1:0] next_lat_orig [NREG];
    logic [NREG-1:0] next_prev_wr;
    fli_op_t next_prev_op;
    logic next_prev_load;
    logic [LAT_W:0] since_take, next_since_take;

    logic [LAT_W:0] src_wait [NSRC];
    logic [LAT_W:0] dst_wait [NDST];
    logic dep_hazard;
    logic lock_conflict;
    logic take;

    logic [WIN_W-1:0] chk_mask [NSTAGE];
    logic [WIN_W-1:0] new_mask [NSTAGE];
    logic [NSTAGE-1:0] stage_conflict;
    logic [WIN_W-1:0] stage_busy [NSTAGE];

    fli_br_state_t br_state;
    fli_br_state_t next_br_state;
    logic [LAT_W-1:0] br_cnt;
    logic [LAT_W-1:0] next_br_cnt;
    logic next_fetch_target;
    logic next_issue_go;
    logic next_issue_pair_ok;
    logic next_stall_dep;
    logic next_stall_lock;

    ////////////////////////////////////////////////////////////////////////////
    // Hazard detection
    always_comb begin
        dep_hazard = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            src_wait[i] = '0;
            if (dec_src_en[i]) begin
                src_wait[i] = eff_wait(lat_left[dec_src_id[i]], lat_orig[dec_src_id[i]], prev_wr[dec_src_id[i]],
                                       prev_op, prev_load, dec_op, i == 0, since_take);
            end
            dep_hazard = dep_hazard || (src_wait[i] != '0); // RULE_17
        end
        for (int d = 0; d < NDST; d++) begin
            dst_wait[d] = '0;
            if (dec_dst_en[d]) begin
                dst_wait[d] = eff_wait(lat_left[dec_dst_id[d]], lat_orig[dec_dst_id[d]], prev_wr[dec_dst_id[d]],
                                       prev_op, prev_load, dec_op, 1'b0, since_take);
            end
            dep_hazard = dep_hazard || (dst_wait[d] != '0); // RULE_17
        end
    end

    // Lock windows per stage, relative to this cycle and to the next
    always_comb begin
        for (int s = 0; s < NSTAGE; s++) begin
            chk_mask[s] = '0;
            new_mask[s] = '0;
            for (int k = 0; k < NLOCK; k++) begin
                if (dec_lock_stage[k] == fli_stage_t'(2'(s + 1))) begin
                    chk_mask[s] = chk_mask[s] | fli_lock_mask(dec_lock_start[k], dec_lock_cycles[k], LOCK_CHK_OFFSET);
                    new_mask[s] = new_mask[s] | fli_lock_mask(dec_lock_start[k], dec_lock_cycles[k],
                                                              LOCK_COMMIT_OFFSET); // RULE_08
                end
            end
        end
    end

    for (genvar g = 0; g < NSTAGE; g++) begin : g_stage
        fli_stage_lock u_lock (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .commit(take),
            .new_mask(new_mask[g]),
            .chk_mask(chk_mask[g]),
            .conflict(stage_conflict[g]),
            .busy(stage_busy[g])
        );
    end

    assign lock_conflict = |stage_conflict; // RULE_18
    assign take = dec_valid && !dep_hazard && !lock_conflict && (br_state == BR_IDLE); // RULE_17 RULE_18

    ////////////////////////////////////////////////////////////////////////////
    // Scoreboard update
    always_comb begin
        for (int r = 0; r < NREG; r++) begin
            next_lat_left[r] = (lat_left[r] != '0) ? lat_left[r] - 5'h1 : '0;
            next_lat_orig[r] = lat_orig[r];
        end
        next_prev_wr = prev_wr;
        next_prev_op = prev_op;
        next_prev_load = prev_load;
        next_since_take = (since_take != '1) ? since_take + 6'h1 : since_take;
        if (take) begin
            next_prev_wr = '0;
            next_since_take = 6'h1;
            next_prev_op = dec_op;
            next_prev_load = dec_is_load;
            for (int d = 0; d < NDST; d++) begin
                if (dec_dst_en[d]) begin
                    next_lat_left[dec_dst_id[d]] = (dec_dst_lat[d] != '0) ? dec_dst_lat[d] - 5'h1 : '0; // RULE_01
                    next_lat_orig[dec_dst_id[d]] = dec_dst_lat[d]; // RULE_04 RULE_05 RULE_06 RULE_07
                    next_prev_wr[dec_dst_id[d]] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < NREG; r++) begin
                lat_left[r] <= '0;
                lat_orig[r] <= '0;
            end
            prev_wr <= '0;
            prev_op <= OP_OTHER;
            prev_load <= 1'b0;
            since_take <= '0;
        end else begin
            lat_left <= next_lat_left;
            lat_orig <= next_lat_orig;
            prev_wr <= next_prev_wr;
            prev_op <= next_prev_op;
            prev_load <= next_prev_load;
            since_take <= next_since_take;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Branch target fetch timing and issue outputs
    always_comb begin
        logic [LAT_W-1:0] blat;
        blat = (dec_op == OP_CBRANCH) ? (dec_br_disp_zero ? LAT_BR_ZERO : LAT_BR_NEAR) : dec_br_lat; // RULE_03
        next_br_state = br_state;
        next_br_cnt = br_cnt;
        next_fetch_target = 1'b0;
        unique case (br_state)
            BR_IDLE: begin
                if (take && (dec_op == OP_BRANCH || dec_op == OP_CBRANCH)) begin
                    if (blat <= LAT_BR_ZERO) begin
                        next_fetch_target = 1'b1; // RULE_02
                    end else begin
                        next_br_state = BR_WAIT;
                        next_br_cnt = blat - LAT_BR_NEAR;
                    end
                end
            end
            BR_WAIT: begin
                if (br_cnt == '0) begin
                    next_fetch_target = 1'b1; // RULE_02
                    next_br_state = BR_IDLE;
                end else begin
                    next_br_cnt = br_cnt - 5'h1;
                end
            end
            default: begin
                next_br_state = BR_IDLE;
            end
        endcase
        next_issue_go = take;
        next_issue_pair_ok = take && !(dec_op == OP_BANK_TOGGLE && dec_pair_ls_fp); // RULE_15
        next_stall_dep = dec_valid && dep_hazard;
        next_stall_lock = dec_valid && lock_conflict;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            br_state <= BR_IDLE;
            br_cnt <= '0;
            fetch_target <= 1'b0;
            issue_go <= 1'b0;
            issue_pair_ok <= 1'b0;
            stall_dep <= 1'b0;
            stall_lock <= 1'b0;
        end else begin
            br_state <= next_br_state;
            br_cnt <= next_br_cnt;
            fetch_target <= next_fetch_target;
            issue_go <= next_issue_go;
            issue_pair_ok <= next_issue_pair_ok;
            stall_dep <= next_stall_dep;
            stall_lock <= next_stall_lock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cbr_zero;
        take && dec_op == OP_CBRANCH && dec_br_disp_zero;
    endsequence

    sequence s_cbr_far;
        take && dec_op == OP_CBRANCH && !dec_br_disp_zero;
    endsequence

    sequence s_src0_hit;
        dec_valid && dec_src_en[0] && prev_wr[dec_src_id[0]] && lat_left[dec_src_id[0]] != 5'h0;
    endsequence

    chk_cbr_zero_disp: assert property (s_cbr_zero |=> fetch_target) // RULE_03
        else $error("zero displacement branch target not fetched after one cycle");

    chk_cbr_far_disp: assert property (s_cbr_far |=> !fetch_target ##1 fetch_target) // RULE_02
        else $error("branch target not fetched after two cycles");

    chk_lat_countdown: assert property (take && dec_dst_en[0] && dec_dst_lat[0] == 5'h3 |=> // RULE_01
        lat_left[$past(dec_dst_id[0])] == 5'h2 ##1 lat_left[$past(dec_dst_id[0], 2)] == 5'h1)
        else $error("destination latency does not count down from its base value");

    chk_lock_window: assert property (take && dec_lock_stage[0] == STG_F1 && dec_lock_start[0] == 5'h2 && // RULE_08
        dec_lock_cycles[0] == 5'h2 |=> stage_busy[1][1:0] == 2'h3)
        else $error("stage lock window not recorded");

    chk_lock_hold: assert property (dec_valid && lock_conflict |=> !issue_go && stall_lock) // RULE_18
        else $error("instruction issued into a locked stage");

    chk_dep_stall: assert property (dec_valid && dec_src_en[0] && src_wait[0] != 6'h0 |=> // RULE_17
        !issue_go && stall_dep)
        else $error("instruction issued while its source latency is pending");

    chk_fp_store_shrink: assert property (s_src0_hit and (prev_op == OP_FP_CALC && dec_op == OP_FP_STORE && // RULE_09
        lat_left[dec_src_id[0]] >= 5'h2) |-> src_wait[0] == {1'b0, lat_left[dec_src_id[0]]} - 6'h1)
        else $error("fp store did not shorten the computation latency");

    chk_ls_raise: assert property (s_src0_hit and (prev_op == OP_LS && dec_op == OP_DBL && // RULE_11
        lat_orig[dec_src_id[0]] < 5'h3) |->
        src_wait[0] == {1'b0, lat_left[dec_src_id[0]]} + 6'h3 - {1'b0, lat_orig[dec_src_id[0]]})
        else $error("short load/store latency not raised to three");

    chk_acc_push: assert property (s_src0_hit and (prev_op == OP_MUL && dec_op == OP_PUSH_ACC && // RULE_12
        lat_orig[dec_src_id[0]] <= 5'h5) |->
        src_wait[0] == {1'b0, lat_left[dec_src_id[0]]} + 6'h5 - {1'b0, lat_orig[dec_src_id[0]]})
        else $error("multiply before accumulator push not set to five");

    chk_pair_block: assert property (take && dec_op == OP_BANK_TOGGLE && dec_pair_ls_fp |=> // RULE_15
        issue_go && !issue_pair_ok)
        else $error("fp load/store paired with bank or size toggle");

endmodule // fli_interlock

// ### common/fli_pkg.sv
// Shared constants, types and helpers for the result-latency interlock.
// Assumes one core clock; the decoder supplies register ids, latencies and lock entries.
package fli_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int REG_W = 6;
    localparam int NREG = 64;
    localparam int LAT_W = 5;
    localparam int NDST = 5;
    localparam int NSRC = 3;
    localparam int NLOCK = 3;
    localparam int NSTAGE = 3;
    localparam int WIN_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // Register ids of the system registers inside the tracked id space
    localparam logic [REG_W-1:0] REG_ACCUMULATOR_HIGH = 6'h30;
    localparam logic [REG_W-1:0] REG_ACCUMULATOR_LOW = 6'h31;
    localparam logic [REG_W-1:0] REG_FP_STATUS_CONTROL = 6'h32;
    localparam logic [REG_W-1:0] REG_FP_COMMUNICATION = 6'h33;

    ////////////////////////////////////////////////////////////////////////////
    // Latency figures, in cycles
    localparam logic [LAT_W-1:0] LAT_BR_NEAR = 5'h2;
    localparam logic [LAT_W-1:0] LAT_BR_ZERO = 5'h1;
    localparam logic [LAT_W-1:0] LAT_FP_SHRINK = 5'h1;
    localparam logic [LAT_W-1:0] LAT_SHIFT_GROW = 5'h1;
    localparam logic [LAT_W-1:0] LAT_LS_MIN = 5'h3;
    localparam logic [LAT_W-1:0] LAT_ACC_PUSH = 5'h5;
    localparam logic [LAT_W-1:0] LAT_MUL_CHAIN = 5'h2;
    localparam logic [LAT_W-1:0] LAT_LDACC_PUSH = 5'h4;
    localparam logic [LAT_W-1:0] LAT_LDACC_MUL = 5'h1;
    localparam logic [LAT_W-1:0] LAT_TRUNC_MOVE = 5'h1;

    // Lock start cycle 1 is the instruction's own decode cycle
    localparam int LOCK_START_FIRST = 1;
    localparam int LOCK_CHK_OFFSET = LOCK_START_FIRST;
    localparam int LOCK_COMMIT_OFFSET = LOCK_START_FIRST + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [4:0] {
        OP_OTHER = 5'h00,
        OP_LS = 5'h01,
        OP_FP_CALC = 5'h02,
        OP_FP_STORE = 5'h03,
        OP_FP_COMMUNICATION_REG_MOVE = 5'h04,
        OP_FP_COMMUNICATION_REG_PUSH = 5'h05,
        OP_DBL = 5'h06,
        OP_INNER = 5'h07,
        OP_MTX = 5'h08,
        OP_MUL = 5'h09,
        OP_MAC = 5'h0a,
        OP_PUSH_ACC = 5'h0b,
        OP_LOAD_ACC = 5'h0c,
        OP_SHIFT_DYN = 5'h0d,
        OP_BANK_TOGGLE = 5'h0e,
        OP_TRUNC_SGL = 5'h0f,
        OP_BRANCH = 5'h10,
        OP_CBRANCH = 5'h11
    } fli_op_t;

    typedef enum logic [1:0] {
        STG_NONE = 2'h0,
        STG_F0 = 2'h1,
        STG_F1 = 2'h2,
        STG_F3 = 2'h3
    } fli_stage_t;

    typedef enum logic [1:0] {
        BR_IDLE = 2'h1,
        BR_WAIT = 2'h2
    } fli_br_state_t;

    // Bit i is set when cycle (i + offset) falls inside the lock window
    function automatic logic [WIN_W-1:0] fli_lock_mask(input logic [LAT_W-1:0] start,
                                                       input logic [LAT_W-1:0] cycles, input int offset);
        logic [WIN_W-1:0] m;
        int pos;
        m = '0;
        for (int i = 0; i < WIN_W; i++) begin
            pos = i + offset;
            m[i] = (pos >= int'(start)) && (pos < int'(start) + int'(cycles));
        end
        return m;
    endfunction

endpackage

// ### logic/fli_stage_lock.sv
// Busy window of one execution stage.
// Assumes the caller supplies masks already aligned to the next and current cycle.
`timescale 1ns/1ps
module fli_stage_lock (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // New lock from the instruction taken this cycle
    input wire logic commit,
    input wire logic [fli_pkg::WIN_W-1:0] new_mask,
    // Window requested by the instruction in decode
    input wire logic [fli_pkg::WIN_W-1:0] chk_mask,
    output logic conflict,
    output logic [fli_pkg::WIN_W-1:0] busy
);
    import fli_pkg::*;

    logic [WIN_W-1:0] next_busy;

    always_comb begin
        next_busy = {1'b0, busy[WIN_W-1:1]};
        if (commit) begin
            next_busy = next_busy | new_mask;
        end
        conflict = |(busy & chk_mask);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= '0;
        end else begin
            busy <= next_busy;
        end
    end

endmodule // fli_stage_lock

// ### testbench/fli_interlock_bench.sv
// Self-checking bench for the result-latency interlock.
// Assumes fli_pkg and fli_interlock are compiled first; the bench drives the decode slot itself.
`timescale 1ns/1ps
module fli_interlock_bench;
    import fli_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic sys_clk, rst_n, dec_valid, dec_is_load, dec_pair_ls_fp, dec_br_disp_zero;
    fli_op_t dec_op;
    logic [NSRC-1:0] dec_src_en;
    logic [REG_W-1:0] dec_src_id [NSRC];
    logic [NDST-1:0] dec_dst_en;
    logic [REG_W-1:0] dec_dst_id [NDST];
    logic [LAT_W-1:0] dec_dst_lat [NDST];
    fli_stage_t dec_lock_stage [NLOCK];
    logic [LAT_W-1:0] dec_lock_start [NLOCK];
    logic [LAT_W-1:0] dec_lock_cycles [NLOCK];
    logic [LAT_W-1:0] dec_br_lat;
    logic issue_go, issue_pair_ok, fetch_target, stall_dep, stall_lock;
    logic [LAT_W-1:0] lt [NDST];
    logic saw_dep, saw_lock;
    int num_errors = 0;
    int checked = 0;

    fli_interlock u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .dec_valid(dec_valid), .dec_op(dec_op),
        .dec_is_load(dec_is_load), .dec_pair_ls_fp(dec_pair_ls_fp), .dec_src_en(dec_src_en),
        .dec_src_id(dec_src_id), .dec_dst_en(dec_dst_en), .dec_dst_id(dec_dst_id),
        .dec_dst_lat(dec_dst_lat), .dec_lock_stage(dec_lock_stage), .dec_lock_start(dec_lock_start),
        .dec_lock_cycles(dec_lock_cycles), .dec_br_lat(dec_br_lat), .dec_br_disp_zero(dec_br_disp_zero),
        .issue_go(issue_go), .issue_pair_ok(issue_pair_ok), .fetch_target(fetch_target),
        .stall_dep(stall_dep), .stall_lock(stall_lock));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %0d expected %0d", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Presents one instruction and returns the cycles until it is taken
    task automatic send(input fli_op_t op, input logic ld, input logic pf, input logic [5:0] sid,
                        input logic [4:0] den, input logic [5:0] db, input fli_stage_t ls,
                        input logic [4:0] lst, input logic [4:0] lcy, output int n);
        dec_valid = 1'b1;
        dec_op = op;
        dec_is_load = ld;
        dec_pair_ls_fp = pf;
        dec_src_en = {2'b00, sid != 6'h00};
        dec_src_id = '{default: sid};
        dec_dst_en = den;
        for (int i = 0; i < NDST; i++) begin
            dec_dst_id[i] = db + 6'(i);
            dec_dst_lat[i] = lt[i];
        end
        for (int i = 0; i < NLOCK; i++) begin
            dec_lock_stage[i] = (i == 0) ? ls : STG_NONE;
            dec_lock_start[i] = lst;
            dec_lock_cycles[i] = lcy;
        end
        n = 0;
        saw_dep = 1'b0;
        saw_lock = 1'b0;
        do begin
            @(negedge sys_clk);
            n++;
            saw_dep |= (stall_dep === 1'b1);
            saw_lock |= (stall_lock === 1'b1);
        end while (issue_go !== 1'b1 && n < 60);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Writer then one follower per destination, in slot order
    task automatic t_dests(input fli_op_t op, input logic [4:0] den);
        int n, done, want;
        send(op, 1'b0, 1'b0, 6'h00, den, 6'h10, STG_NONE, 5'h0, 5'h0, n);
        done = 0;
        for (int i = 0; i < NDST; i++) begin
            if (den[i]) begin
                send(OP_OTHER, 1'b0, 1'b0, 6'h10 + 6'(i), 5'h00, 6'h00, STG_NONE, 5'h0, 5'h0, n);
                want = int'(lt[i]) - done;
                if (want < 1) want = 1;
                check(8'(n), 8'(want));
                done += n;
            end
        end
    endtask

    // Writer of one register, then a follower of the given class reading it
    task automatic t_adj(input fli_op_t wop, input logic ld, input logic [4:0] wl, input fli_op_t fop,
                         input logic [5:0] rid, input int exp);
        int n;
        lt = '{wl, 5'h0, 5'h0, 5'h0, 5'h0};
        send(wop, ld, 1'b0, 6'h00, 5'h01, rid, STG_NONE, 5'h0, 5'h0, n);
        send(fop, 1'b0, 1'b0, rid, 5'h00, 6'h00, STG_NONE, 5'h0, 5'h0, n);
        check(8'(n), 8'(exp));
        check(8'(saw_dep), 8'(exp > 1));
    endtask

    task automatic t_branch(input fli_op_t op, input logic dz, input logic [4:0] bl, input int exp);
        int n, k;
        dec_br_disp_zero = dz;
        dec_br_lat = bl;
        lt = '{default: 5'h0};
        send(op, 1'b0, 1'b0, 6'h00, 5'h00, 6'h00, STG_NONE, 5'h0, 5'h0, n);
        dec_valid = 1'b0;
        k = 1;
        while (fetch_target !== 1'b1 && k < 40) begin
            @(negedge sys_clk);
            k++;
        end
        check(8'(k), 8'(exp));
        @(negedge sys_clk);
        check(8'(fetch_target), 8'h00);
    endtask

    task automatic t_lock(input fli_stage_t sa, input logic [4:0] ssa, input logic [4:0] ca,
                          input fli_stage_t sb, input logic [4:0] ssb, input int exp);
        int n;
        send(OP_OTHER, 1'b0, 1'b0, 6'h00, 5'h00, 6'h00, sa, ssa, ca, n);
        send(OP_OTHER, 1'b0, 1'b0, 6'h00, 5'h00, 6'h00, sb, ssb, 5'h1, n);
        check(8'(n), 8'(exp));
        check(8'(saw_lock), 8'(exp > 1));
    endtask

    task automatic t_pair(input fli_op_t op, input logic pf, input logic exp);
        int n;
        send(op, 1'b0, pf, 6'h00, 5'h00, 6'h00, STG_NONE, 5'h0, 5'h0, n);
        check(8'(issue_pair_ok), 8'(exp));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        dec_valid = 1'b0;
        dec_op = OP_OTHER;
        dec_is_load = 1'b0;
        dec_pair_ls_fp = 1'b0;
        dec_src_en = '0;
        dec_src_id = '{default: 6'h00};
        dec_dst_en = '0;
        dec_dst_id = '{default: 6'h00};
        dec_dst_lat = '{default: 5'h0};
        dec_lock_stage = '{default: STG_NONE};
        dec_lock_start = '{default: 5'h0};
        dec_lock_cycles = '{default: 5'h0};
        dec_br_lat = 5'h0;
        dec_br_disp_zero = 1'b0;
        lt = '{default: 5'h0};
        repeat (16) @(negedge sys_clk);
        check(8'({issue_go, issue_pair_ok, fetch_target, stall_dep, stall_lock}), 8'h00);
        rst_n = 1'b1;
        t_adj(OP_OTHER, 1'b0, 5'h3, OP_OTHER, 6'h05, 3);
        lt = '{5'h7, 5'h8, 5'h9, 5'h0, 5'h0};
        t_dests(OP_DBL, 5'h07);
        lt = '{5'h5, 5'h5, 5'h6, 5'h7, 5'h8};
        t_dests(OP_MTX, 5'h1f);
        lt = '{5'h1, 5'h2, 5'h3, 5'h4, 5'h0};
        t_dests(OP_MAC, 5'h0f);
        lt = '{5'h3, 5'h4, 5'h0, 5'h0, 5'h0};
        t_dests(OP_MUL, 5'h03);
        t_adj(OP_FP_CALC, 1'b0, 5'h3, OP_FP_STORE, 6'h02, 2);
        t_adj(OP_FP_CALC, 1'b0, 5'h3, OP_FP_COMMUNICATION_REG_MOVE, 6'h33, 2);
        t_adj(OP_FP_CALC, 1'b0, 5'h3, OP_FP_COMMUNICATION_REG_PUSH, 6'h33, 2);
        t_adj(OP_OTHER, 1'b1, 5'h2, OP_SHIFT_DYN, 6'h03, 3);
        t_adj(OP_LS, 1'b0, 5'h1, OP_DBL, 6'h04, 3);
        t_adj(OP_LS, 1'b0, 5'h0, OP_INNER, 6'h04, 3);
        t_adj(OP_LS, 1'b0, 5'h2, OP_MTX, 6'h04, 3);
        t_adj(OP_MUL, 1'b0, 5'h3, OP_PUSH_ACC, 6'h30, 5);
        t_adj(OP_MAC, 1'b0, 5'h3, OP_PUSH_ACC, 6'h31, 5);
        t_adj(OP_MUL, 1'b0, 5'h4, OP_MUL, 6'h31, 2);
        t_adj(OP_MAC, 1'b0, 5'h4, OP_MAC, 6'h30, 2);
        t_adj(OP_LOAD_ACC, 1'b1, 5'h2, OP_PUSH_ACC, 6'h30, 4);
        t_adj(OP_LOAD_ACC, 1'b1, 5'h3, OP_MUL, 6'h31, 1);
        t_adj(OP_TRUNC_SGL, 1'b0, 5'h3, OP_FP_COMMUNICATION_REG_MOVE, 6'h33, 1);
        t_branch(OP_CBRANCH, 1'b1, 5'h0, 1);
        t_branch(OP_CBRANCH, 1'b0, 5'h0, 2);
        t_branch(OP_BRANCH, 1'b0, 5'h4, 4);
        t_lock(STG_F1, 5'h2, 5'h6, STG_F1, 5'h2, 6);
        t_lock(STG_F1, 5'h3, 5'h3, STG_F1, 5'h2, 4);
        t_lock(STG_F1, 5'h2, 5'h2, STG_F1, 5'h1, 3);
        t_lock(STG_F1, 5'h3, 5'h1, STG_F1, 5'h2, 2);
        t_lock(STG_F0, 5'h2, 5'h4, STG_F1, 5'h2, 1);
        t_lock(STG_F3, 5'h2, 5'ha, STG_F3, 5'h2, 10);
        t_pair(OP_BANK_TOGGLE, 1'b1, 1'b0);
        t_pair(OP_BANK_TOGGLE, 1'b0, 1'b1);
        t_pair(OP_OTHER, 1'b1, 1'b1);
        print_verdict();
    end

    // Cuts a hang short; the sequence above needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end

endmodule // fli_interlock_bench
